/* File: include/rtca_pkg.sv */
// constants, field layout and types for the rtc alarm, control and status block
// Function
// - alarm one at 07h-0Ah, alarm two 0Bh-0Dh
// - bit 7 masks; unmasked fields must equal time
// - mask patterns pick second/min/hour/day repeat
// - bit 6 chooses day-of-week or date match
// - match checked each second, sets alarm flag
// - pin asserts on flag, enable and route select
// - pin stays asserted until host clears flag
// - backup enable keeps pin alive on backup
// - control bit 7 stops oscillator, resets zero
// - rate bits pick four wave rates, reset 11
// - control bit 2 routes wave or interrupts
// - interrupt is enabled first, second or both flags
// - backup and alarm enables reset to zero
// - stop flag set on oscillator stop, write-zero
// - stop flag set at power-up and disable
// - status bits 1:0 alarm flags, write-zero clears
// - charger key 1010 enables, reset off
// - diode field 00 or 11 disables charger
// - resistor field selects resistor, 00 disables
// - pointer wraps from 10h to 00h
// - values and compares are bcd
package rtca_pkg;

	// ======================================================
	// register map
	localparam int         ADDR_W        = 5;
	localparam logic [4:0] OFF_TIME_LAST = 5'h0_6;
	localparam logic [4:0] OFF_AL1_FIRST = 5'h0_7;
	localparam logic [4:0] OFF_AL1_LAST  = 5'h0_A;
	localparam logic [4:0] OFF_AL2_FIRST = 5'h0_B;
	localparam logic [4:0] OFF_AL2_LAST  = 5'h0_D;
	localparam logic [4:0] OFF_CTRL      = 5'h0_E;
	localparam logic [4:0] OFF_STAT      = 5'h0_F;
	localparam logic [4:0] OFF_CHG       = 5'h1_0;
	localparam logic [4:0] OFF_FIRST     = 5'h0_0;
	localparam int         ALARM_REGS    = 7;

	// ======================================================
	// field positions
	localparam int MASK_BIT      = 7;
	localparam int DAY_SEL_BIT   = 6;
	localparam int CTL_OSC_DIS   = 7;
	localparam int CTL_BACKUP_OE = 5;
	localparam int CTL_RS_HI     = 4;
	localparam int CTL_RS_LO     = 3;
	localparam int CTL_IRQ_ROUTE = 2;
	localparam int CTL_AL2_IE    = 1;
	localparam int CTL_AL1_IE    = 0;
	localparam int ST_OSC_STOP   = 7;
	localparam int ST_AL2_FLAG   = 1;
	localparam int ST_AL1_FLAG   = 0;

	localparam logic [7:0] CTL_USED = 8'hBF;
	localparam logic [7:0] ST_USED  = 8'h83;

	// ======================================================
	// reset values
	localparam logic [7:0] CTL_RST   = 8'h18;
	localparam logic [7:0] STAT_RST  = 8'h80;
	localparam logic [7:0] CHG_RST   = 8'h00;
	localparam logic [7:0] ALARM_RST = 8'h00;

	// ======================================================
	// charger and rate encodings
	localparam logic [3:0] CHG_KEY     = 4'hA;
	localparam logic [1:0] DIODE_OFF_A = 2'h0;
	localparam logic [1:0] DIODE_OFF_B = 2'h3;
	localparam logic [1:0] DIODE_ONE   = 2'h1;
	localparam logic [1:0] RO_OFF   = 2'h0;
	localparam logic [1:0] RATE_1HZ  = 2'h0;
	localparam logic [1:0] RATE_4K   = 2'h1;
	localparam logic [1:0] RATE_8K   = 2'h2;
	localparam logic [1:0] RATE_32K  = 2'h3;

	// ======================================================
	// timing
	localparam int CLK_NS    = 8;
	localparam int STOP_NS   = 2000;
	localparam int STOP_CYC  = (STOP_NS + CLK_NS - 1) / CLK_NS;
	localparam int SEC_DIV_W = 15;

	// ======================================================
	// carriers
	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] date;
		logic [7:0] day;
		logic [7:0] hour;
		logic [7:0] minute;
		logic [7:0] second;
	} rtca_time_t;

	typedef struct packed {
		logic       enable;
		logic       one_diode;
		logic [1:0] resistor_select;
	} rtca_charge_t;

endpackage

/* File: rtl/rtca_alarm_match.sv */
// one alarm comparator: masked bcd field compare against current time
`timescale 1ns/100ps
module rtca_alarm_match #(
	parameter bit HAS_SECONDS = 1'b1
) (
	input  wire rtca_pkg::rtca_time_t now,
	input  wire logic [7:0]           al_sec,
	input  wire logic [7:0]           al_min,
	input  wire logic [7:0]           al_hour,
	input  wire logic [7:0]           al_daydate,
	output logic                      match
);
	logic sec_ok;
	logic min_ok;
	logic hour_ok;
	logic dd_ok;
	logic [5:0] dd_now;

	// ======================================================
	// masked compares
	always_comb begin
		// without a seconds register the alarm lands on second 00
		if (HAS_SECONDS) begin
			sec_ok = al_sec[rtca_pkg::MASK_BIT] | (now.second[6:0] == al_sec[6:0]);
		end else begin
			sec_ok = (now.second[6:0] == 7'h0_0);
		end
		min_ok  = al_min[rtca_pkg::MASK_BIT] | (now.minute[6:0] == al_min[6:0]);
		hour_ok = al_hour[rtca_pkg::MASK_BIT] | (now.hour[6:0] == al_hour[6:0]);
		dd_now  = al_daydate[rtca_pkg::DAY_SEL_BIT] ? now.day[5:0] : now.date[5:0];
		dd_ok   = al_daydate[rtca_pkg::MASK_BIT] | (dd_now == al_daydate[5:0]);
		match   = sec_ok & min_ok & hour_ok & dd_ok;
	end

endmodule

/* File: rtl/rtca_core.sv */
// alarm, control, status and charge-select logic with pointer register port
`timescale 1ns/100ps
module rtca_core #(
	parameter int STOP_CYC  = rtca_pkg::STOP_CYC,
	parameter int SEC_DIV_W = rtca_pkg::SEC_DIV_W
) (
	input  wire logic                 clk,
	input  wire logic                 srst,
	input  wire logic                 osc_clk,
	input  wire logic                 power_fail,
	input  wire rtca_pkg::rtca_time_t time_now,
	input  wire logic                 acc_set_ptr,
	input  wire logic [4:0]           acc_ptr,
	input  wire logic                 acc_wr,
	input  wire logic [7:0]           acc_wdata,
	input  wire logic                 acc_rd,
	output logic [7:0]                acc_rdata,
	output logic                      acc_rvalid,
	output logic                      time_wr,
	output logic [2:0]                time_wr_idx,
	output logic [7:0]                time_wr_data,
	output logic                      second_tick,
	output logic                      osc_running,
	output logic                      wave_or_irq_output,
	output logic                      wave_or_irq_oe,
	output rtca_pkg::rtca_charge_t    charge
);

	// refuse sizes the counters and rate taps cannot serve
	if (STOP_CYC < 2 || STOP_CYC > 65535) begin : g_bad_stop
		$error("STOP_CYC out of range");
	end
	if (SEC_DIV_W < 3 || SEC_DIV_W > 24) begin : g_bad_div
		$error("SEC_DIV_W out of range");
	end

	// ======================================================
	// helpers
	function automatic logic [4:0] ptr_step(input logic [4:0] p);
		ptr_step = (p >= rtca_pkg::OFF_CHG) ? rtca_pkg::OFF_FIRST : 5'(p + 5'h0_1);
	endfunction

	// ======================================================
	// pin synchronisers
	logic osc_meta;
	logic osc_sync;
	logic osc_prev;
	logic pf_meta;
	logic pf_sync;

	always_ff @(posedge clk) begin
		if (srst) begin
			osc_meta <= 1'b0;
			osc_sync <= 1'b0;
			osc_prev <= 1'b0;
			pf_meta  <= 1'b0;
			pf_sync  <= 1'b0;
		end else begin
			osc_meta <= osc_clk;
			osc_sync <= osc_meta;
			osc_prev <= osc_sync;
			pf_meta  <= power_fail;
			pf_sync  <= pf_meta;
		end
	end

	// ======================================================
	// register state
	logic [4:0] ptr;
	logic [7:0] ctrl;
	logic [7:0] stat;
	logic [7:0] chg;
	logic [7:0] alarm_mem [rtca_pkg::ALARM_REGS];
	logic [4:0] next_ptr;
	logic [7:0] next_ctrl;
	logic [7:0] next_stat;
	logic [7:0] next_chg;
	logic [7:0] next_alarm_mem [rtca_pkg::ALARM_REGS];
	logic [7:0] next_acc_rdata;
	logic       next_acc_rvalid;
	logic       next_time_wr;
	logic [2:0] next_time_wr_idx;
	logic [7:0] next_time_wr_data;

	logic       acc_ok;
	logic       do_wr;
	logic       do_rd;
	logic       set_a1;
	logic       set_a2;
	logic       set_osf;
	logic       match1;
	logic       match2;
	logic [55:0] time_flat;
	logic [4:0]  al_idx;

	// ======================================================
	// oscillator state
	logic [SEC_DIV_W-1:0] div;
	logic [15:0]          stop_cnt;
	logic                 stopped;
	logic                 dis_prev;
	logic [SEC_DIV_W-1:0] next_div;
	logic [15:0]          next_stop_cnt;
	logic                 next_stopped;
	logic                 next_second_tick;
	logic                 osc_edge;
	logic                 osc_dis;

	assign osc_dis   = ctrl[rtca_pkg::CTL_OSC_DIS];
	assign time_flat = time_now;
	assign al_idx    = 5'(ptr - rtca_pkg::OFF_AL1_FIRST);

	rtca_alarm_match #(
		.HAS_SECONDS (1'b1)
	) u_match1 (
		.now        (time_now),
		.al_sec     (alarm_mem[0]),
		.al_min     (alarm_mem[1]),
		.al_hour    (alarm_mem[2]),
		.al_daydate (alarm_mem[3]),
		.match      (match1)
	);

	rtca_alarm_match #(
		.HAS_SECONDS (1'b0)
	) u_match2 (
		.now        (time_now),
		.al_sec     (8'h00),
		.al_min     (alarm_mem[4]),
		.al_hour    (alarm_mem[5]),
		.al_daydate (alarm_mem[6]),
		.match      (match2)
	);

	// ======================================================
	// oscillator divider and stop detection
	always_comb begin
		// a disabled oscillator is treated as stopped; its pin edges are ignored
		osc_edge         = osc_sync & ~osc_prev & ~osc_dis;
		next_div         = osc_edge ? SEC_DIV_W'(div + 1'b1) : div;
		next_second_tick = osc_edge & (&div);
		next_stop_cnt    = stop_cnt;
		if (osc_edge) begin
			next_stop_cnt = 16'h0_000;
		end else if (stop_cnt < 16'(STOP_CYC)) begin
			next_stop_cnt = 16'(stop_cnt + 16'h0_001);
		end
		next_stopped = (next_stop_cnt >= 16'(STOP_CYC));
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			div         <= '0;
			stop_cnt    <= 16'h0_000;
			stopped     <= 1'b1;
			dis_prev    <= 1'b0;
			second_tick <= 1'b0;
		end else begin
			div         <= next_div;
			stop_cnt    <= next_stop_cnt;
			stopped     <= next_stopped;
			dis_prev    <= osc_dis;
			second_tick <= next_second_tick;
		end
	end

	assign osc_running = ~stopped & ~osc_dis;

	// ======================================================
	// register access and flags
	always_comb begin
		acc_ok  = ~pf_sync;
		do_wr   = acc_ok & ~acc_set_ptr & acc_wr;
		do_rd   = acc_ok & ~acc_set_ptr & ~acc_wr & acc_rd;
		set_a1  = second_tick & match1;
		set_a2  = second_tick & match2;
		set_osf = (next_stopped & ~stopped) | (osc_dis & ~dis_prev);

		next_ptr          = ptr;
		next_ctrl         = ctrl;
		next_stat         = stat;
		next_chg          = chg;
		next_alarm_mem    = alarm_mem;
		next_acc_rdata    = acc_rdata;
		next_acc_rvalid   = 1'b0;
		next_time_wr      = 1'b0;
		next_time_wr_idx  = time_wr_idx;
		next_time_wr_data = time_wr_data;

		if (acc_ok && acc_set_ptr) begin
			next_ptr = (acc_ptr > rtca_pkg::OFF_CHG) ? rtca_pkg::OFF_FIRST : acc_ptr;
		end else if (do_wr || do_rd) begin
			next_ptr = ptr_step(ptr);
		end

		if (do_wr) begin
			if (ptr <= rtca_pkg::OFF_TIME_LAST) begin
				next_time_wr      = 1'b1;
				next_time_wr_idx  = ptr[2:0];
				next_time_wr_data = acc_wdata;
			end else if (ptr <= rtca_pkg::OFF_AL2_LAST) begin
				next_alarm_mem[al_idx[2:0]] = acc_wdata;
			end else if (ptr == rtca_pkg::OFF_CTRL) begin
				next_ctrl = acc_wdata & rtca_pkg::CTL_USED;
			end else if (ptr == rtca_pkg::OFF_STAT) begin
				next_stat = stat & (acc_wdata | ~rtca_pkg::ST_USED);
			end else begin
				next_chg = acc_wdata;
			end
		end

		// a set in the same cycle as a clear wins
		next_stat[rtca_pkg::ST_AL1_FLAG] = next_stat[rtca_pkg::ST_AL1_FLAG] | set_a1;
		next_stat[rtca_pkg::ST_AL2_FLAG] = next_stat[rtca_pkg::ST_AL2_FLAG] | set_a2;
		next_stat[rtca_pkg::ST_OSC_STOP] = next_stat[rtca_pkg::ST_OSC_STOP] | set_osf;
		next_stat = next_stat & rtca_pkg::ST_USED;

		if (do_rd) begin
			next_acc_rvalid = 1'b1;
			if (ptr <= rtca_pkg::OFF_TIME_LAST) begin
				next_acc_rdata = time_flat[8*ptr[2:0] +: 8];
			end else if (ptr <= rtca_pkg::OFF_AL2_LAST) begin
				next_acc_rdata = alarm_mem[al_idx[2:0]];
			end else if (ptr == rtca_pkg::OFF_CTRL) begin
				next_acc_rdata = ctrl;
			end else if (ptr == rtca_pkg::OFF_STAT) begin
				next_acc_rdata = stat;
			end else begin
				next_acc_rdata = chg;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ptr          <= rtca_pkg::OFF_FIRST;
			ctrl         <= rtca_pkg::CTL_RST;
			stat         <= rtca_pkg::STAT_RST;
			chg          <= rtca_pkg::CHG_RST;
			for (int i = 0; i < rtca_pkg::ALARM_REGS; i++) begin
				alarm_mem[i] <= rtca_pkg::ALARM_RST;
			end
			acc_rdata    <= 8'h00;
			acc_rvalid   <= 1'b0;
			time_wr      <= 1'b0;
			time_wr_idx  <= 3'h0;
			time_wr_data <= 8'h00;
		end else begin
			ptr          <= next_ptr;
			ctrl         <= next_ctrl;
			stat         <= next_stat;
			chg          <= next_chg;
			alarm_mem    <= next_alarm_mem;
			acc_rdata    <= next_acc_rdata;
			acc_rvalid   <= next_acc_rvalid;
			time_wr      <= next_time_wr;
			time_wr_idx  <= next_time_wr_idx;
			time_wr_data <= next_time_wr_data;
		end
	end

	// ======================================================
	// shared open-drain output and charger select
	logic                   wave;
	logic                   irq_act;
	logic                   next_oe;
	rtca_pkg::rtca_charge_t next_charge;
	logic [1:0]             rate;
	logic [1:0]             diode;
	logic [1:0]             ro;

	always_comb begin
		rate = {ctrl[rtca_pkg::CTL_RS_HI], ctrl[rtca_pkg::CTL_RS_LO]};
		case (rate)
			rtca_pkg::RATE_1HZ: wave = div[SEC_DIV_W-1];
			rtca_pkg::RATE_4K:  wave = div[2];
			rtca_pkg::RATE_8K:  wave = div[1];
			rtca_pkg::RATE_32K: wave = osc_sync;
			default:            wave = 1'b1;
		endcase
		irq_act = ctrl[rtca_pkg::CTL_IRQ_ROUTE] &
		          ((ctrl[rtca_pkg::CTL_AL1_IE] & stat[rtca_pkg::ST_AL1_FLAG]) |
		           (ctrl[rtca_pkg::CTL_AL2_IE] & stat[rtca_pkg::ST_AL2_FLAG]));
		// active is pulled low; square wave low phase also pulls low
		next_oe = ctrl[rtca_pkg::CTL_IRQ_ROUTE] ? irq_act : ~wave;
		if (pf_sync && !ctrl[rtca_pkg::CTL_BACKUP_OE]) begin
			next_oe = 1'b0;
		end

		diode = chg[3:2];
		ro    = chg[1:0];
		next_charge.enable          = (chg[7:4] == rtca_pkg::CHG_KEY) &&
		                              (diode != rtca_pkg::DIODE_OFF_A) &&
		                              (diode != rtca_pkg::DIODE_OFF_B) &&
		                              (ro != rtca_pkg::RO_OFF);
		next_charge.one_diode       = (diode == rtca_pkg::DIODE_ONE);
		next_charge.resistor_select = ro;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			wave_or_irq_oe <= 1'b0;
			charge         <= '0;
		end else begin
			wave_or_irq_oe <= next_oe;
			charge         <= next_charge;
		end
	end

	// open drain: only ever drives low
	assign wave_or_irq_output = 1'b0;

endmodule

/* File: tb/rtca_host.sv */
// host model: byte transfers on the pointer register port
`timescale 1ns/100ps
module rtca_host (
	input  wire logic       clk,
	output logic            acc_set_ptr,
	output logic [4:0]      acc_ptr,
	output logic            acc_wr,
	output logic [7:0]      acc_wdata,
	output logic            acc_rd,
	input  wire logic [7:0] acc_rdata
);
	initial begin
		acc_set_ptr = 1'b0;
		acc_ptr = 5'h00;
		acc_wr = 1'b0;
		acc_wdata = 8'h00;
		acc_rd = 1'b0;
	end
	// released lines show the inverse so stale values never pass
	task automatic point(input logic [4:0] a);
		@(negedge clk);
		acc_set_ptr = 1'b1;
		acc_ptr = a;
		@(negedge clk);
		acc_set_ptr = 1'b0;
		acc_ptr = ~a;
	endtask
	task automatic wr(input logic [7:0] d);
		@(negedge clk);
		acc_wr = 1'b1;
		acc_wdata = d;
		@(negedge clk);
		acc_wr = 1'b0;
		acc_wdata = ~d;
	endtask
	task automatic rd(output logic [7:0] d);
		@(negedge clk);
		acc_rd = 1'b1;
		@(negedge clk);
		acc_rd = 1'b0;
		@(negedge clk);
		d = acc_rdata;
	endtask
endmodule

/* File: tb/rtca_core_checker.sv */
// assertions on the register port, tick and pins of the core
`timescale 1ns/100ps
module rtca_core_checker #(
	parameter int STOP_CYC  = rtca_pkg::STOP_CYC,
	parameter int SEC_DIV_W = rtca_pkg::SEC_DIV_W
) (
	input wire logic                   clk,
	input wire logic                   srst,
	input wire logic                   power_fail,
	input wire logic                   acc_set_ptr,
	input wire logic                   acc_wr,
	input wire logic                   acc_rd,
	input wire logic                   acc_rvalid,
	input wire logic                   time_wr,
	input wire logic [2:0]             time_wr_idx,
	input wire logic                   second_tick,
	input wire logic                   wave_or_irq_output,
	input wire rtca_pkg::rtca_charge_t charge
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	// ==========================================
	// read requests, pin sync needs margin
	sequence rd_alone;
		acc_rd && !acc_set_ptr && !acc_wr;
	endsequence
	sequence quiet_rd;
		!power_fail [*5] ##0 rd_alone;
	endsequence
	sequence fail_rd;
		power_fail [*5] ##0 acc_rd;
	endsequence
	a_read_answer: assert property (quiet_rd |=> acc_rvalid)
		else $error("read not answered");
	a_read_cause: assert property (acc_rvalid |-> $past(acc_rd))
		else $error("read data without request");
	a_fail_block: assert property (fail_rd |=> !acc_rvalid)
		else $error("read answered during power fail");
	a_pin_opendrain: assert property (wave_or_irq_output == 1'b0)
		else $error("open drain data not low");
	a_tick_spacing: assert property (second_tick |=> !second_tick [*8])
		else $error("second tick too close");
	a_charge_res: assert property (charge.enable |-> charge.resistor_select != 2'h0)
		else $error("charger on without resistor");
	a_time_cause: assert property (time_wr |-> $past(acc_wr) && !$past(acc_set_ptr))
		else $error("time write without request");
	a_time_index: assert property (time_wr |-> time_wr_idx <= 3'h6)
		else $error("time index out of range");
endmodule
bind rtca_core rtca_core_checker #(.STOP_CYC(STOP_CYC), .SEC_DIV_W(SEC_DIV_W)) u_checker (
	.clk(clk), .srst(srst), .power_fail(power_fail), .acc_set_ptr(acc_set_ptr),
	.acc_wr(acc_wr), .acc_rd(acc_rd), .acc_rvalid(acc_rvalid), .time_wr(time_wr),
	.time_wr_idx(time_wr_idx), .second_tick(second_tick),
	.wave_or_irq_output(wave_or_irq_output), .charge(charge)
);

/* File: tb/tb_rtca_core.sv */
// self-checking bench for the alarm, control and status core
`timescale 1ns/100ps
module tb_rtca_core;
	logic                   clk, srst, osc_clk, power_fail;
	rtca_pkg::rtca_time_t   tnow;
	logic                   acc_set_ptr, acc_wr, acc_rd, acc_rvalid;
	logic [4:0]             acc_ptr;
	logic [7:0]             acc_wdata, acc_rdata, d, time_wr_data;
	logic                   time_wr, second_tick, osc_running, oe, prev, wio;
	logic [2:0]             time_wr_idx;
	rtca_pkg::rtca_charge_t charge;
	int                     miscompares, samples_checked, n;
	logic [7:0]             cdat [8] = '{8'hA5, 8'hA6, 8'hA7, 8'hA9, 8'hA3, 8'hAF, 8'h55, 8'hA4};
	logic [3:0]             cexp [8] = '{4'hD, 4'hE, 4'hF, 4'h9, 4'h0, 4'h0, 4'h0, 4'h0};
	int                     rlo [4] = '{1, 7, 15, 63};
	rtca_host host (.clk(clk), .acc_set_ptr(acc_set_ptr), .acc_ptr(acc_ptr), .acc_wr(acc_wr),
		.acc_wdata(acc_wdata), .acc_rd(acc_rd), .acc_rdata(acc_rdata));
	// short divider keeps a second at 640 clocks
	rtca_core #(.SEC_DIV_W(5)) dut (.clk(clk), .srst(srst), .osc_clk(osc_clk), .power_fail(power_fail),
		.time_now(tnow), .acc_set_ptr(acc_set_ptr), .acc_ptr(acc_ptr), .acc_wr(acc_wr),
		.acc_wdata(acc_wdata), .acc_rd(acc_rd), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
		.time_wr(time_wr), .time_wr_idx(time_wr_idx), .time_wr_data(time_wr_data),
		.second_tick(second_tick), .osc_running(osc_running), .wave_or_irq_output(wio),
		.wave_or_irq_oe(oe), .charge(charge));
	// ==========================================
	// helpers
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic wreg(input logic [4:0] a, input logic [7:0] v);
		host.point(a);
		host.wr(v);
	endtask
	task automatic rdat(input logic [4:0] a, input logic [7:0] e);
		host.point(a);
		host.rd(d);
		check($sformatf("reg_%h", a), d, e);
	endtask
	task automatic tick;
		n = 0;
		while (second_tick !== 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		check("tick_seen", {7'h0, second_tick}, 8'h01);
		repeat (3) @(negedge clk);
	endtask
	// ==========================================
	// clocks and watchdog
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		osc_clk = 1'b0;
		#37;
		forever #80 osc_clk = ~osc_clk;
	end
	initial begin
		repeat (30000) @(posedge clk);
		miscompares++;
		tally_and_finish();
	end
	// ==========================================
	// tests
	initial begin
		srst = 1'b1;
		power_fail = 1'b0;
		tnow = '0;
		tnow.second = 8'h37;
		repeat (8) @(negedge clk);
		srst = 1'b0;
		rdat(5'h0E, 8'h18);
		host.rd(d);
		check("status", d, 8'h80);
		host.rd(d);
		check("charger", d, 8'h00);
		host.rd(d);
		check("wrap", d, 8'h37);
		repeat (40) @(negedge clk);
		check("osc_run", {7'h0, osc_running}, 8'h01);
		wreg(5'h0F, 8'hFF);
		rdat(5'h0F, 8'h80);
		wreg(5'h0F, 8'h00);
		rdat(5'h0F, 8'h00);
		wreg(5'h0E, 8'h7F);
		rdat(5'h0E, 8'h3F);
		for (int r = 0; r < 4; r++) begin
			wreg(5'h0E, 8'(r << 3));
			n = 0;
			prev = oe;
			repeat (640) begin
				@(negedge clk);
				n += int'(oe !== prev);
				prev = oe;
			end
			check("wave_edges", {7'h0, n >= rlo[r] && n <= rlo[r] + 2}, 8'h01);
		end
		wreg(5'h07, 8'h05);
		repeat (3) host.wr(8'h80);
		rdat(5'h0A, 8'h80);
		wreg(5'h0E, 8'h05);
		tnow.second = 8'h04;
		tick();
		check("irq_nomatch", {7'h0, oe}, 8'h00);
		tnow.second = 8'h05;
		tick();
		check("irq_match", {7'h0, oe}, 8'h01);
		tnow.second = 8'h06;
		tick();
		check("irq_held", {7'h0, oe}, 8'h01);
		rdat(5'h0F, 8'h01);
		wreg(5'h0F, 8'h00);
		repeat (3) @(negedge clk);
		check("irq_clear", {7'h0, oe}, 8'h00);
		tnow.day = 8'h03;
		tnow.date = 8'h07;
		tnow.second = 8'h05;
		wreg(5'h08, 8'h00);
		host.wr(8'h00);
		host.wr(8'h43);
		tick();
		rdat(5'h0F, 8'h01);
		wreg(5'h0A, 8'h03);
		wreg(5'h0F, 8'h00);
		tick();
		rdat(5'h0F, 8'h00);
		wreg(5'h0B, 8'h80);
		repeat (2) host.wr(8'h80);
		wreg(5'h0E, 8'h06);
		tnow.second = 8'h00;
		tick();
		rdat(5'h0F, 8'h02);
		check("irq_two", {7'h0, oe}, 8'h01);
		power_fail = 1'b1;
		repeat (6) @(negedge clk);
		check("pf_release", {7'h0, oe}, 8'h00);
		power_fail = 1'b0;
		repeat (6) @(negedge clk);
		wreg(5'h0E, 8'h26);
		power_fail = 1'b1;
		repeat (6) @(negedge clk);
		check("pf_backed", {7'h0, oe}, 8'h01);
		rdat(5'h0E, 8'h02);
		power_fail = 1'b0;
		tnow.second = 8'h30;
		repeat (6) @(negedge clk);
		wreg(5'h0F, 8'h00);
		wreg(5'h0E, 8'h80);
		repeat (3) @(negedge clk);
		check("osc_off", {7'h0, osc_running}, 8'h00);
		rdat(5'h0F, 8'h80);
		for (int i = 0; i < 8; i++) begin
			wreg(5'h10, cdat[i]);
			repeat (2) @(negedge clk);
			check("charge", {4'h0, (i < 4) ? 4'(charge) : {charge.enable, 3'h0}}, {4'h0, cexp[i]});
		end
		wreg(5'h00, 8'h12);
		check("time_wr_on", {7'h0, time_wr}, 8'h01);
		@(negedge clk);
		check("time_wr_off", {7'h0, time_wr}, 8'h00);
		check("pin_data", {7'h0, wio}, 8'h00);
		check("time_data", time_wr_data, 8'h12);
		check("time_idx", {5'h0, time_wr_idx}, 8'h00);
		tally_and_finish();
	end
endmodule
